// ---- hw/sac_pkg.sv ----
// Package of constants and types for the converter conversion control block
//------------------------------------------------------------------------------
// Functional notes
// - Result right aligned, left when adjust set
// - Low byte read locks result until high
// - Locked completion drops result, still flags
// - Start bit launches conversion, reads busy
// - Channel change waits for conversion end
// - Trigger rising edge resets prescaler, starts
// - Edges during conversion ignored, no relaunch
// - Trigger flag must clear before next event
// - Own flag source: restart after every completion
// - Software start still works under auto trigger
// - Prescaler divides 2..128, reset while disabled
// - Start waits for next converter clock edge
// - Normal 13 cycles, first 25 cycles
// - Sample at 1.5, first at 14.5
// - Completion stores result, flags, clears start unless free running
// - Auto trigger: sample at 2, 13.5 total
// - Selections inert until enable set
// - Selections copied until start, resume last cycle
// - Free running change applies one conversion later
// - Clearing enable aborts running conversion
// - Channel codes 00..11 select inputs 0..3
// - Reference bit: 0 supply, 1 internal
// - Adjust change re-presents stored result now
//------------------------------------------------------------------------------
package sac_pkg;

  localparam logic [2:0] SAC_OFF_CHANNEL_REF  = 3'h0;
  localparam logic [2:0] SAC_OFF_CONTROL      = 3'h1;
  localparam logic [2:0] SAC_OFF_TRIGGER      = 3'h2;
  localparam logic [2:0] SAC_OFF_RESULT_LOW   = 3'h3;
  localparam logic [2:0] SAC_OFF_RESULT_HIGH  = 3'h4;

  localparam int SAC_BIT_REFERENCE   = 6;
  localparam int SAC_BIT_LEFT_ADJUST = 5;
  localparam int SAC_BIT_CHANNEL_LO  = 0;
  localparam int SAC_BIT_ENABLE      = 7;
  localparam int SAC_BIT_START       = 6;
  localparam int SAC_BIT_AUTO        = 5;
  localparam int SAC_BIT_FLAG        = 4;
  localparam int SAC_BIT_DIVIDER_LO  = 0;
  localparam int SAC_BIT_TRIGGER_LO  = 0;

  localparam logic [2:0] SAC_TRIGGER_OWN_FLAG = 3'h0;
  localparam logic [7:0] SAC_BYTE_RESET       = 8'h00;
  localparam logic [9:0] SAC_RESULT_RESET     = 10'h000;

  // Converter timing; totals and sample points in converter clock half periods
  localparam int SAC_NORMAL_CYCLES       = 13;
  localparam int SAC_FIRST_CYCLES        = 25;
  localparam logic [5:0] SAC_NORMAL_TOTAL = 6'(2 * SAC_NORMAL_CYCLES);
  localparam logic [5:0] SAC_FIRST_TOTAL  = 6'(2 * SAC_FIRST_CYCLES);
  localparam logic [5:0] SAC_AUTO_TOTAL   = 6'h1b;
  localparam logic [5:0] SAC_NORMAL_SAMPLE = 6'h03;
  localparam logic [5:0] SAC_FIRST_SAMPLE  = 6'h1d;
  localparam logic [5:0] SAC_AUTO_SAMPLE   = 6'h04;
  localparam int SAC_SYNC_CPU_CYCLES     = 3;

  typedef enum logic [1:0]
  {
    SAC_IDLE      = 2'b00,
    SAC_WAIT_EDGE = 2'b01,
    SAC_CONVERT   = 2'b11
  } sac_phase_type;

  typedef struct packed
  {
    logic [1:0] channel;
    logic       reference;
  } sac_select_type;

  typedef struct packed
  {
    sac_select_type                 hold_sel;
    logic                           left_adjust;
    logic                           enable;
    logic                           auto_en;
    logic                           flag;
    logic [2:0]                     div_sel;
    logic [2:0]                     trig_sel;
    sac_select_type                 act_sel;
    logic [9:0]                     result;
    logic                           lock;
    logic [6:0]                     presc;
    sac_phase_type                  phase;
    logic [5:0]                     half;
    logic [5:0]                     total;
    logic [5:0]                     sample;
    logic                           first;
    logic                           trig_prev;
    logic [SAC_SYNC_CPU_CYCLES-1:0] trig_pipe;
    logic [7:0]                     rdata;
    logic                           sample_hold;
    logic                           done;
  } sac_state_type;

endpackage

// ---- hw/sac_conversion_control.sv ----
// Conversion control, prescaler, selection buffering and result presentation
`timescale 1ns/1ps
module sac_conversion_control
  import sac_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:1] trigger_events,
  input  wire logic [9:0] analog_result,
  output logic            analog_enable,
  output logic      [1:0] input_channel_select,
  output logic            reference_select,
  output logic            sample_hold,
  output logic            conversion_active,
  output logic            conversion_done
);

  sac_state_type state_reg;
  sac_state_type state_next;

  //----------------------------------------------------------------------------
  // Decoding helpers
  //----------------------------------------------------------------------------
  function automatic logic [6:0] divider_mask(input logic [2:0] code);
    logic [6:0] m;
    m = 7'h01;
    if (code != 3'h0)
    begin
      m = 7'((8'h01 << code) - 8'h01);
    end
    return m;
  endfunction

  function automatic logic [7:0] present_byte(input logic [9:0] r, input logic left, input logic high);
    logic [7:0] b;
    b = SAC_BYTE_RESET;
    if (left)
    begin
      b = high ? r[9:2] : {r[1:0], 6'h00};
    end
    else
    begin
      b = high ? {6'h00, r[9:8]} : r[7:0];
    end
    return b;
  endfunction

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  logic [6:0] mask;
  logic       rise_edge;
  logic       fall_edge;
  logic       trig_level;
  logic       trig_edge;
  logic       busy;
  logic       sw_start;
  logic       free_run;
  logic       complete;
  logic [5:0] half_inc;

  always_comb
  begin
    state_next = state_reg;
    state_next.sample_hold = 1'b0;
    state_next.done = 1'b0;
    mask = divider_mask(state_reg.div_sel);
    rise_edge = (state_reg.presc & mask) == mask;
    fall_edge = (state_reg.presc & mask) == (mask >> 1);
    trig_level = 1'b0;
    if (state_reg.trig_sel != SAC_TRIGGER_OWN_FLAG)
    begin
      trig_level = trigger_events[state_reg.trig_sel];
    end
    // A still-high event flag gives no new edge, so the source must be cleared first
    trig_edge = trig_level && !state_reg.trig_prev;
    busy = (state_reg.phase != SAC_IDLE) || (state_reg.trig_pipe != '0);
    free_run = state_reg.auto_en && (state_reg.trig_sel == SAC_TRIGGER_OWN_FLAG);
    sw_start = 1'b0;
    complete = 1'b0;
    half_inc = 6'(state_reg.half + 6'h01);
    state_next.trig_prev = trig_level;

    // Prescaler runs only while enabled
    if (state_reg.enable)
    begin
      state_next.presc = 7'(state_reg.presc + 7'h01);
    end
    else
    begin
      state_next.presc = 7'h00;
    end

    // Selection copy from the holding register
    if (state_reg.enable)
    begin
      if (state_reg.phase != SAC_CONVERT)
      begin
        state_next.act_sel = state_reg.hold_sel;
      end
      else if (state_reg.half >= 6'(state_reg.total - 6'h02))
      begin
        state_next.act_sel = state_reg.hold_sel;
      end
    end

    // Register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        SAC_OFF_CHANNEL_REF:
        begin
          state_next.hold_sel.channel = reg_wdata[SAC_BIT_CHANNEL_LO +: 2];
          state_next.hold_sel.reference = reg_wdata[SAC_BIT_REFERENCE];
          state_next.left_adjust = reg_wdata[SAC_BIT_LEFT_ADJUST];
        end
        SAC_OFF_CONTROL:
        begin
          state_next.enable = reg_wdata[SAC_BIT_ENABLE];
          state_next.auto_en = reg_wdata[SAC_BIT_AUTO];
          state_next.div_sel = reg_wdata[SAC_BIT_DIVIDER_LO +: 3];
          if (reg_wdata[SAC_BIT_FLAG])
          begin
            state_next.flag = 1'b0;
          end
          sw_start = reg_wdata[SAC_BIT_START] && reg_wdata[SAC_BIT_ENABLE];
        end
        SAC_OFF_TRIGGER:
        begin
          state_next.trig_sel = reg_wdata[SAC_BIT_TRIGGER_LO +: 3];
        end
        default:
        begin
        end
      endcase
    end

    // Reads are answered one cycle later
    state_next.rdata = SAC_BYTE_RESET;
    if (reg_read)
    begin
      unique case (reg_addr)
        SAC_OFF_CHANNEL_REF:
        begin
          state_next.rdata[SAC_BIT_CHANNEL_LO +: 2] = state_reg.hold_sel.channel;
          state_next.rdata[SAC_BIT_REFERENCE] = state_reg.hold_sel.reference;
          state_next.rdata[SAC_BIT_LEFT_ADJUST] = state_reg.left_adjust;
        end
        SAC_OFF_CONTROL:
        begin
          state_next.rdata[SAC_BIT_ENABLE] = state_reg.enable;
          state_next.rdata[SAC_BIT_START] = busy;
          state_next.rdata[SAC_BIT_AUTO] = state_reg.auto_en;
          state_next.rdata[SAC_BIT_FLAG] = state_reg.flag;
          state_next.rdata[SAC_BIT_DIVIDER_LO +: 3] = state_reg.div_sel;
        end
        SAC_OFF_TRIGGER:
        begin
          state_next.rdata[SAC_BIT_TRIGGER_LO +: 3] = state_reg.trig_sel;
        end
        SAC_OFF_RESULT_LOW:
        begin
          state_next.rdata = present_byte(state_reg.result, state_reg.left_adjust, 1'b0);
          state_next.lock = 1'b1;
        end
        SAC_OFF_RESULT_HIGH:
        begin
          state_next.rdata = present_byte(state_reg.result, state_reg.left_adjust, 1'b1);
          state_next.lock = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Trigger path: three cycles of synchronisation before the prescaler restart
    state_next.trig_pipe = {state_reg.trig_pipe[SAC_SYNC_CPU_CYCLES-2:0], 1'b0};
    if (state_reg.enable && state_reg.auto_en && trig_edge && !busy)
    begin
      state_next.trig_pipe[0] = 1'b1;
    end

    // Conversion sequencing
    unique case (state_reg.phase)
      SAC_IDLE:
      begin
        if (state_reg.trig_pipe[SAC_SYNC_CPU_CYCLES-1])
        begin
          state_next.presc = 7'h00;
          state_next.phase = SAC_CONVERT;
          state_next.half = 6'h00;
          state_next.total = state_reg.first ? SAC_FIRST_TOTAL : SAC_AUTO_TOTAL;
          state_next.sample = state_reg.first ? SAC_FIRST_SAMPLE : SAC_AUTO_SAMPLE;
          state_next.first = 1'b0;
        end
        // Enable and start may come in one write; sw_start already needs the enable bit
        else if (sw_start)
        begin
          state_next.phase = SAC_WAIT_EDGE;
        end
      end
      SAC_WAIT_EDGE:
      begin
        if (rise_edge)
        begin
          state_next.phase = SAC_CONVERT;
          state_next.half = 6'h00;
          state_next.total = state_reg.first ? SAC_FIRST_TOTAL : SAC_NORMAL_TOTAL;
          state_next.sample = state_reg.first ? SAC_FIRST_SAMPLE : SAC_NORMAL_SAMPLE;
          state_next.first = 1'b0;
        end
      end
      SAC_CONVERT:
      begin
        if (rise_edge || fall_edge)
        begin
          state_next.half = half_inc;
          if (half_inc == state_reg.sample)
          begin
            state_next.sample_hold = 1'b1;
          end
          if (half_inc == state_reg.total)
          begin
            complete = 1'b1;
          end
        end
      end
      default:
      begin
        state_next.phase = SAC_IDLE;
      end
    endcase

    if (complete)
    begin
      state_next.done = 1'b1;
      state_next.flag = 1'b1;
      if (!state_reg.lock)
      begin
        state_next.result = analog_result;
      end
      if (free_run)
      begin
        // Restart at once, independent of whether the flag was cleared
        state_next.half = 6'h00;
        state_next.total = SAC_NORMAL_TOTAL;
        state_next.sample = SAC_NORMAL_SAMPLE;
      end
      else
      begin
        state_next.phase = SAC_IDLE;
      end
    end

    // Disabling aborts everything and rearms the long first conversion
    if (!state_next.enable)
    begin
      state_next.phase = SAC_IDLE;
      state_next.trig_pipe = '0;
      state_next.sample_hold = 1'b0;
      state_next.first = 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= '0;
      state_reg.phase <= SAC_IDLE;
      state_reg.result <= SAC_RESULT_RESET;
      state_reg.rdata <= SAC_BYTE_RESET;
      state_reg.first <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign reg_rdata            = state_reg.rdata;
  assign analog_enable        = state_reg.enable;
  assign input_channel_select = state_reg.act_sel.channel;
  assign reference_select     = state_reg.act_sel.reference;
  assign sample_hold          = state_reg.sample_hold;
  // Only the converting code has the upper phase bit set
  assign conversion_active    = state_reg.phase[1];
  assign conversion_done      = state_reg.done;

endmodule

// ---- testbench/sac_conversion_control_asserts.sv ----
// Port checker for the conversion control block
`timescale 1ns/1ps
module sac_conversion_control_asserts
  import sac_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:1] trigger_events,
  input wire logic [9:0] analog_result,
  input wire logic       analog_enable,
  input wire logic [1:0] input_channel_select,
  input wire logic       reference_select,
  input wire logic       sample_hold,
  input wire logic       conversion_active,
  input wire logic       conversion_done
);
  //------
  // Properties
  //------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence conv_begin;
    $rose(conversion_active);
  endsequence
  sequence quiet_start;
    (!sample_hold && !conversion_done)[*3];
  endsequence
  sample_in_conv_a : assert property (sample_hold |-> conversion_active)
    else $error("sample pulse outside a conversion");
  early_sample_a : assert property (conv_begin |-> quiet_start)
    else $error("sample or completion too soon after start");
  done_after_conv_a : assert property (conversion_done |-> $past(conversion_active))
    else $error("completion without a conversion");
  done_pulse_a : assert property (conversion_done |=> !conversion_done)
    else $error("completion pulse longer than one cycle");
  sel_locked_a : assert property (conv_begin |=> ($stable(input_channel_select) && $stable(reference_select))[*8])
    else $error("selection moved early in a conversion");
  idle_when_off_a : assert property (!analog_enable |-> !conversion_active && !sample_hold)
    else $error("conversion runs while disabled");
  enable_follow_a : assert property (reg_write && reg_addr == SAC_OFF_CONTROL |=>
    analog_enable == $past(reg_wdata[SAC_BIT_ENABLE]))
    else $error("enable output does not follow write");
  sel_frozen_a : assert property (!analog_enable && $past(!analog_enable) |-> $stable(input_channel_select))
    else $error("selection applied while disabled");
endmodule

bind sac_conversion_control sac_conversion_control_asserts i_chk (.clock, .sys_rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .trigger_events, .analog_result, .analog_enable, .input_channel_select,
  .reference_select, .sample_hold, .conversion_active, .conversion_done);

// ---- testbench/sac_analog_model.sv ----
// Analog side model answering each sample with a code tagged by selection
`timescale 1ns/1ps
module sac_analog_model
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       analog_enable,
  input  wire logic       sample_hold,
  input  wire logic [1:0] input_channel_select,
  input  wire logic       reference_select,
  input  wire logic [6:0] sample_byte,
  output logic      [9:0] analog_result
);
  //------
  // Sampling
  //------
  // Code carries the selection so a late channel switch shows in the result
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      analog_result <= 10'h000;
    else if (sample_hold && analog_enable)
      analog_result <= {reference_select, input_channel_select, sample_byte};
  end
endmodule

// ---- testbench/sac_conversion_control_tb.sv ----
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
module sac_conversion_control_tb
  import sac_pkg::*;
;
  logic       clock, sys_rst, reg_write, reg_read, reference_select, adj, locked;
  logic       analog_enable, sample_hold, conversion_active, conversion_done;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [7:1] trigger_events;
  logic [6:0] sample_byte;
  logic [9:0] analog_result, stored;
  logic [1:0] input_channel_select;
  logic [9:0] exp_q[$];
  int         num_errors, tests_run, seed, c, n;

  sac_conversion_control i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .trigger_events, .analog_result, .analog_enable, .input_channel_select, .reference_select, .sample_hold,
    .conversion_active, .conversion_done);
  sac_analog_model i_model (.clock, .sys_rst, .analog_enable, .sample_hold, .input_channel_select,
    .reference_select, .sample_byte, .analog_result);

  //------
  // Tasks
  //------
  task automatic check(input logic [9:0] seen, input logic [9:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Lowering then one idle edge, so no strobe is set twice in a time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic readback();
    rd(SAC_OFF_RESULT_LOW, rv);
    check(10'(rv), 10'(adj ? {stored[1:0], 6'h00} : stored[7:0]));
    rd(SAC_OFF_RESULT_HIGH, rv);
    check(10'(rv), 10'(adj ? stored[9:2] : {6'h00, stored[9:8]}));
    locked = 1'b0;
  endtask

  task automatic wait_done(input int lo, input int hi);
    c = 0;
    do
    begin
      @(posedge clock);
      #1;
      c++;
    end
    while (conversion_done !== 1'b1 && c < 2000);
    @(posedge clock);
    check(10'(c >= lo && c <= hi), 10'h001);
  endtask

  task automatic run(input logic [7:0] sel, input logic [7:0] ctl, input int src, input int lo, input int hi);
    logic [6:0] b;
    logic [9:0] nv;
    b = 7'($random(seed));
    sample_byte <= b;
    exp_q.push_back({sel[6], sel[1:0], b});
    adj = sel[5];
    wr(SAC_OFF_CHANNEL_REF, sel);
    wr(SAC_OFF_TRIGGER, 8'(src));
    wr(SAC_OFF_CONTROL, ctl);
    // The edge is only seen at the next clock, so the busy read waits one cycle
    if (src > 0)
    begin
      trigger_events[src] <= 1'b1;
      @(posedge clock);
    end
    rd(SAC_OFF_CONTROL, rv);
    check(10'(rv[SAC_BIT_START]), 10'h001);
    wait_done(lo, hi);
    nv = exp_q.pop_front();
    if (!locked)
      stored = nv;
    rd(SAC_OFF_CONTROL, rv);
    check(10'(rv[SAC_BIT_FLAG]), 10'h001);
    wr(SAC_OFF_CONTROL, (ctl & 8'hbf) | 8'h10);
  endtask

  //------
  // Stimulus
  //------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    seed = 32'he105;
    {sys_rst, reg_write, reg_read, reg_addr, reg_wdata} = {1'b1, 13'h0000};
    {trigger_events, sample_byte, stored, locked, adj} = 26'h0000000;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), rv);
      check(10'(rv), 10'h000);
    end
    for (int i = 0; i < 4; i++)
    begin
      run(8'((i % 2) << 6 | (i / 2) << 5 | i), 8'hc0, 0, i == 0 ? 46 : 22, i == 0 ? 52 : 28);
      readback();
    end
    wr(SAC_OFF_CHANNEL_REF, 8'h00);
    adj = 1'b0;
    readback();
    $display("test single conversions done");
    rd(SAC_OFF_RESULT_LOW, rv);
    locked = 1'b1;
    run(8'h02, 8'hc0, 0, 22, 28);
    readback();
    run(8'h01, 8'hc3, 0, 98, 112);
    readback();
    $display("test lock and divider done");
    wr(SAC_OFF_CONTROL, 8'hc3);
    repeat (8) @(posedge clock);
    wr(SAC_OFF_CHANNEL_REF, 8'h02);
    repeat (20) @(posedge clock);
    #1 check(10'(input_channel_select), 10'h001);
    wait_done(40, 112);
    #1 check(10'(input_channel_select), 10'h002);
    @(posedge clock);
    n = 1 + ($unsigned($random(seed)) % 7);
    run(8'h03, 8'ha0, n, 25, 35);
    readback();
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clock);
      #1 check(10'(conversion_active), 10'h000);
    end
    @(posedge clock);
    trigger_events <= 7'h00;
    $display("test auto trigger done");
    run(8'h00, 8'he0, 0, 22, 28);
    for (int k = 0; k < 3; k++)
      wait_done(1, 30);
    wr(SAC_OFF_CONTROL, 8'h00);
    #1 check(10'(conversion_active), 10'h000);
    @(posedge clock);
    rd(SAC_OFF_CONTROL, rv);
    check(10'(rv[SAC_BIT_START]), 10'h000);
    $display("test free running done");
    complete_run();
  end
endmodule
